// file: logic/serial_vid_receiver.sv
// Serial voltage-identification slave receiver with boot latch and offsets.
// Assumes the link pins and straps are asynchronous to clk and are
// synchronised here; the link clock is far slower than clk.
`timescale 1ns/100ps
`default_nettype none

// Operation
// R01: The host is the only master; this block only receives and acknowledges.
// R02: A command is start, address, write bit, ack, data byte, ack, stop.
// R03: Address bits 6:4 must be 110b, otherwise the byte is ignored.
// R04: Acknowledge the address only when it is valid.
// R05: Address bit 1 targets core, bit 0 targets northbridge; both allowed.
// R06: Address bit 2 selects an absent plane and moves no output.
// R07: Address bit 3 is reserved and has no function.
// R08: Data bit 7 is the active-low power-save hint.
// R09: Data bits 6:0 are the voltage code for each selected output.
// R10: Code 0 is 1.55 V, each step lowers 12.5 mV, to code 7Bh.
// R11: Codes 7Ch to 7Fh turn off only the selected outputs.
// R12: Acknowledge the data byte when all eight bits arrived.
// R13: New targets are applied only after the stop condition.
// R14: After start-up both outputs hold the latched boot voltage.
// R15: Each output has its own 16-level offset strap, +50 to -43.75 mV.
// R16: Commands are accepted only while host power-ok is high.
// R17: Power-ok low restores boot voltage and ignores the link.
// R18: Enable rising latches the boot voltage from clock and data levels.
// R19: Unacknowledged or unstopped transactions, or no select bits, change nothing.
module serial_vid_receiver
  import svid_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link pins, data is open drain
  input wire logic vid_serial_clock,
  input wire logic vid_serial_data_in,
  output logic vid_serial_data_out,
  output logic vid_serial_data_oe,
  // Control pins
  input wire logic enable,
  input wire logic host_power_ok,
  input wire logic [3:0] core_offset_strap,
  input wire logic [3:0] nb_offset_strap,
  // Regulator targets
  output logic [6:0] core_voltage_code,
  output logic core_off,
  output logic [6:0] nb_voltage_code,
  output logic nb_off,
  output logic power_save_hint_n,
  output logic signed [16:0] core_offset_uv,
  output logic signed [16:0] nb_offset_uv,
  output logic core_update,
  output logic nb_update
);

  typedef struct packed {
    logic [1:0] scl_sync, sda_sync, en_sync, pok_sync;
    logic [7:0] prog_sync0, prog_sync1;
    logic scl_d, sda_d, en_d;
    rx_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shift, data;
    logic [1:0] sel;
    logic pending, ack_drive;
    logic [6:0] boot_code, core_code, nb_code;
    logic core_off, nb_off, hint_n;
    logic signed [16:0] core_ofs, nb_ofs;
    logic core_upd, nb_upd;
  } state_s;

  state_s q, next_q;
  logic scl, sda, scl_rise, scl_fall;
  logic start_seen, stop_seen, pok;
  logic [6:0] boot_sel;

  // Second synchroniser stage only
  assign scl = q.scl_sync[1];
  assign sda = q.sda_sync[1];
  assign pok = q.pok_sync[1];
  assign scl_rise = scl && !q.scl_d;
  assign scl_fall = !scl && q.scl_d;
  assign start_seen = scl && q.scl_d && q.sda_d && !sda;
  assign stop_seen = scl && q.scl_d && !q.sda_d && sda;

  // Boot voltage from static clock and data levels
  always_comb begin
    case ({scl, sda})
      2'b00: boot_sel = boot_code_00;
      2'b01: boot_sel = boot_code_01;
      2'b10: boot_sel = boot_code_10;
      default: boot_sel = boot_code_11;
    endcase
  end

  // Next-state logic
  always_comb begin
    next_q = q;
    next_q.scl_sync = {q.scl_sync[0], vid_serial_clock};
    next_q.sda_sync = {q.sda_sync[0], vid_serial_data_in};
    next_q.en_sync = {q.en_sync[0], enable};
    next_q.pok_sync = {q.pok_sync[0], host_power_ok};
    next_q.prog_sync0 = {core_offset_strap, nb_offset_strap};
    next_q.prog_sync1 = q.prog_sync0;
    next_q.scl_d = scl;
    next_q.sda_d = sda;
    next_q.en_d = q.en_sync[1];
    next_q.core_upd = 1'b0;
    next_q.nb_upd = 1'b0;
    // Offset levels, each output from its own strap
    next_q.core_ofs = 17'(offset_top_uv - offset_step_uv * int'(q.prog_sync1[7:4])); // R15
    next_q.nb_ofs = 17'(offset_top_uv - offset_step_uv * int'(q.prog_sync1[3:0])); // R15
    if (q.en_sync[1] && !q.en_d) begin
      // Latch boot code and start both outputs there
      next_q.boot_code = boot_sel; // R18
      next_q.core_code = boot_sel; // R14
      next_q.nb_code = boot_sel; // R14
      next_q.core_off = 1'b0;
      next_q.nb_off = 1'b0;
      next_q.hint_n = 1'b1;
      next_q.core_upd = 1'b1;
      next_q.nb_upd = 1'b1;
    end
    if (!pok || !q.en_sync[1]) begin
      // Link ignored; restore boot target on power-ok loss
      next_q.state = st_idle; // R16
      next_q.pending = 1'b0;
      next_q.ack_drive = 1'b0;
      if (q.en_sync[1] && q.en_d && (q.core_code != q.boot_code || q.nb_code != q.boot_code
          || q.core_off || q.nb_off)) begin
        next_q.core_code = q.boot_code; // R17
        next_q.nb_code = q.boot_code; // R17
        next_q.core_off = 1'b0;
        next_q.nb_off = 1'b0;
        next_q.core_upd = 1'b1;
        next_q.nb_upd = 1'b1;
      end
    end else if (start_seen) begin
      // Start or repeated start discards any unfinished command
      next_q.state = st_addr; // R19
      next_q.bit_cnt = 4'h0;
      next_q.pending = 1'b0;
      next_q.ack_drive = 1'b0;
    end else if (stop_seen) begin
      // Apply only on stop after a fully acknowledged command
      if (q.pending) begin // R13
        if (q.sel[1]) begin // R05
          next_q.core_code = q.data[6:0]; // R09
          next_q.core_off = (q.data[6:0] >= code_off_first); // R11
          next_q.core_upd = 1'b1;
        end
        if (q.sel[0]) begin // R05
          next_q.nb_code = q.data[6:0]; // R09
          next_q.nb_off = (q.data[6:0] >= code_off_first); // R11
          next_q.nb_upd = 1'b1;
        end
        // A command with no output selected leaves the hint alone too
        if (q.sel != 2'b00) next_q.hint_n = q.data[data_hint_bit]; // R08 R19
      end
      next_q.state = st_idle;
      next_q.pending = 1'b0;
      next_q.ack_drive = 1'b0;
    end else begin
      case (q.state)
        st_idle: begin
          next_q.ack_drive = 1'b0;
        end
        st_addr, st_data: begin
          if (scl_rise) begin
            next_q.shift = {q.shift[6:0], sda};
            next_q.bit_cnt = q.bit_cnt + 4'h1;
          end
          if (scl_fall && q.bit_cnt == 4'h8) begin
            next_q.bit_cnt = 4'h0;
            if (q.state == st_addr) begin
              // Prefix and write bit checked; bits 3 and 2 ignored
              if (q.shift[7:5] == addr_prefix && !q.shift[0]) begin // R03 R07 R06
                next_q.sel = {q.shift[addr_core_bit + 1], q.shift[addr_nb_bit + 1]};
                next_q.ack_drive = 1'b1; // R04
                next_q.state = st_ack_addr;
              end else begin
                next_q.state = st_idle; // R03
              end
            end else begin
              next_q.data = q.shift;
              next_q.ack_drive = 1'b1; // R12
              next_q.state = st_ack_data;
            end
          end
        end
        st_ack_addr: begin
          if (scl_fall) begin
            next_q.ack_drive = 1'b0;
            next_q.state = st_data;
          end
        end
        st_ack_data: begin
          if (scl_fall) begin
            next_q.ack_drive = 1'b0;
            next_q.pending = 1'b1; // R19
            next_q.state = st_idle;
          end
        end
        default: begin
          next_q.state = st_idle;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.scl_sync <= 2'b11;
      q.sda_sync <= 2'b11;
      q.scl_d <= 1'b1;
      q.sda_d <= 1'b1;
      q.state <= st_idle;
      q.boot_code <= code_reset;
      q.core_code <= code_reset;
      q.nb_code <= code_reset;
      q.hint_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // Outputs; slave only pulls data low to acknowledge
  assign vid_serial_data_out = 1'b0; // R01
  assign vid_serial_data_oe = q.ack_drive;
  assign core_voltage_code = q.core_code; // R10
  assign nb_voltage_code = q.nb_code; // R10
  assign core_off = q.core_off;
  assign nb_off = q.nb_off;
  assign power_save_hint_n = q.hint_n;
  assign core_offset_uv = q.core_ofs;
  assign nb_offset_uv = q.nb_ofs;
  assign core_update = q.core_upd;
  assign nb_update = q.nb_upd;

  // Ack on address only for a valid prefix
  property p_addr_ack;
    @(posedge clk) disable iff (!rstn)
      (q.state == st_addr && next_q.state == st_ack_addr) |-> q.shift[7:5] == addr_prefix;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("ack on bad address"); // R04
  // Target changes come only with a stop, enable edge or power-ok loss
  property p_apply_on_stop;
    @(posedge clk) disable iff (!rstn)
      ($changed(q.core_code) && pok && q.en_d && $past(pok) && $past(q.en_d))
        |-> $past(stop_seen && q.pending);
  endproperty
  a_apply_on_stop: assert property (p_apply_on_stop) else $error("early apply"); // R13
  // Off flag follows the code range
  property p_off_code;
    @(posedge clk) disable iff (!rstn)
      q.core_upd && pok |-> q.core_off == (q.core_code >= code_off_first);
  endproperty
  a_off_code: assert property (p_off_code) else $error("off flag wrong"); // R11
  // Power-ok low returns to boot code on the next cycle
  sequence s_pok_lost;
    !pok && q.en_sync[1] && q.en_d;
  endsequence
  property p_pok_boot;
    @(posedge clk) disable iff (!rstn)
      s_pok_lost ##1 !pok |-> q.core_code == q.boot_code && q.nb_code == q.boot_code;
  endproperty
  a_pok_boot: assert property (p_pok_boot) else $error("no boot return"); // R17
  // No acknowledge while power-ok is low
  property p_pok_quiet;
    @(posedge clk) disable iff (!rstn)
      !pok |=> !vid_serial_data_oe;
  endproperty
  a_pok_quiet: assert property (p_pok_quiet) else $error("driving while ignored"); // R16
  // Offset follows strap
  property p_offset;
    @(posedge clk) disable iff (!rstn)
      $stable(q.prog_sync1) |=> core_offset_uv ==
        17'(offset_top_uv - offset_step_uv * int'($past(q.prog_sync1[7:4])));
  endproperty
  a_offset: assert property (p_offset) else $error("core offset wrong"); // R15
  // Enable rise latches boot code
  property p_boot_latch;
    @(posedge clk) disable iff (!rstn)
      (q.en_sync[1] && !q.en_d) |=> q.boot_code == $past(boot_sel);
  endproperty
  a_boot_latch: assert property (p_boot_latch) else $error("boot latch wrong"); // R18
  // Unselected core output does not change on stop
  property p_sel_only;
    @(posedge clk) disable iff (!rstn)
      (stop_seen && pok && q.en_d && q.en_sync[1] && !q.sel[1]) |=> $stable(q.core_code);
  endproperty
  a_sel_only: assert property (p_sel_only) else $error("unselected change"); // R19

endmodule

`default_nettype wire

// file: logic/svid_pkg.sv
// Constants for the serial voltage-identification receiver.
// Assumes a 100 MHz system clock; the link runs far slower.
package svid_pkg;
  // Address byte layout
  localparam logic [2:0] addr_prefix = 3'h6;
  localparam int addr_prefix_hi = 6;
  localparam int addr_prefix_lo = 4;
  localparam int addr_core_bit = 1;
  localparam int addr_nb_bit = 0;
  // Data byte layout
  localparam int data_hint_bit = 7;
  // Codes at or above this turn the selected output off
  localparam logic [6:0] code_off_first = 7'h7c;
  // Target after reset, before any boot latch
  localparam logic [6:0] code_reset = 7'h00;
  // Boot voltages as codes: 1.1 V, 1.0 V, 0.9 V, 0.8 V
  localparam logic [6:0] boot_code_00 = 7'h24;
  localparam logic [6:0] boot_code_01 = 7'h2c;
  localparam logic [6:0] boot_code_10 = 7'h34;
  localparam logic [6:0] boot_code_11 = 7'h3c;
  // Offset strap: 16 levels, code 0 = +50 mV, 6.25 mV a step down
  localparam int offset_top_uv = 50000;
  localparam int offset_step_uv = 6250;
  // Receiver states
  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_addr = 5'b00010,
    st_ack_addr = 5'b00100,
    st_data = 5'b01000,
    st_ack_data = 5'b10000
  } rx_state_e;
endpackage

// file: verification/svid_host.sv
// Behavioural host master driving the serial voltage-identification link.
// Assumes the data wire is resolved outside, with a pull-up when released.
`timescale 1ns/100ps
`default_nettype none

module svid_host (
  // Link pins driven by the host
  output logic scl,
  output logic sda,
  // Resolved data wire
  input wire logic sda_wire
);
  // Lines idle high; the clock stands still between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Static levels, used for the boot latch
  task automatic set_lines(input logic c, input logic d);
    scl = c;
    sda = d;
  endtask

  // One bit: data moves only while the clock is low
  task automatic put_bit(input logic b);
    scl = 1'b0;
    #40 sda = b;
    #22.5 scl = 1'b1;
    #62.5;
  endtask

  // Start, address with write bit, ack, data, ack, optional stop
  task automatic send(input logic [6:0] addr, input logic [7:0] data, input logic stop,
                      output logic ack_a, output logic ack_d);
    logic [7:0] a;
    a = {addr, 1'b0};
    sda = 1'b0;
    // Start hold of 61 ns keeps every later link edge off the rising clk edges
    #61;
    for (int i = 7; i >= 0; i--) put_bit(a[i]);
    put_bit(1'b1);
    ack_a = ~sda_wire;
    for (int i = 7; i >= 0; i--) put_bit(data[i]);
    put_bit(1'b1);
    ack_d = ~sda_wire;
    // Stop is a data rise while the clock is high
    scl = 1'b0;
    #40 sda = ~stop;
    #22.5 scl = 1'b1;
    #40 sda = 1'b1;
    #22.5;
  endtask
endmodule

`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the serial voltage-identification receiver.
// Assumes the host model in svid_host.sv and an open-drain data wire.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import svid_pkg::*;
  logic clk, rstn, enable, host_power_ok, scl, sda, sda_out, sda_oe;
  logic [3:0] core_offset_strap, nb_offset_strap;
  logic [6:0] core_code, nb_code, exp_core, exp_nb;
  logic core_off, nb_off, hint_n, core_update, nb_update, exp_coff, exp_noff, exp_hint;
  logic signed [16:0] core_uv, nb_uv;
  wire logic sda_wire;
  int n_mismatch, checked, n_cu, n_nu;

  // Open drain with pull-up: device pulls low while enabled
  assign sda_wire = sda & (~sda_oe | sda_out);

  serial_vid_receiver i_serial_vid_receiver (.clk(clk), .rstn(rstn),
    .vid_serial_clock(scl), .vid_serial_data_in(sda_wire), .vid_serial_data_out(sda_out),
    .vid_serial_data_oe(sda_oe), .enable(enable), .host_power_ok(host_power_ok),
    .core_offset_strap(core_offset_strap), .nb_offset_strap(nb_offset_strap),
    .core_voltage_code(core_code), .core_off(core_off), .nb_voltage_code(nb_code),
    .nb_off(nb_off), .power_save_hint_n(hint_n), .core_offset_uv(core_uv),
    .nb_offset_uv(nb_uv), .core_update(core_update), .nb_update(nb_update));

  svid_host i_svid_host (.scl(scl), .sda(sda), .sda_wire(sda_wire));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count update pulses half a cycle after the edge that launches them
  always @(negedge clk) begin
    if (core_update === 1'b1) n_cu++;
    if (nb_update === 1'b1) n_nu++;
  end

  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    checked++;
    if (exp !== got) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare codes, off flags and hint with the expected state
  task automatic cmp_all();
    chk("core code", exp_core, core_code);
    chk("nb code", exp_nb, nb_code);
    chk("core off", exp_coff, core_off);
    chk("nb off", exp_noff, nb_off);
    chk("hint", exp_hint, hint_n);
  endtask

  // One command; expectations follow from address, data, stop and power-ok
  task automatic cmd(input logic [6:0] a, input logic [7:0] d, input logic stop);
    logic aa, ad, ok, sc, sn;
    int cu, nu;
    cu = n_cu;
    nu = n_nu;
    ok = (a[6:4] == 3'b110) && (host_power_ok === 1'b1);
    i_svid_host.send(a, d, stop, aa, ad);
    repeat (10) @(negedge clk);
    chk("addr ack", ok, aa);
    if (ok) chk("data ack", 1'b1, ad);
    sc = ok & stop & a[1];
    sn = ok & stop & a[0];
    if (sc) {exp_core, exp_coff} = {d[6:0], d[6:0] >= code_off_first};
    if (sn) {exp_nb, exp_noff} = {d[6:0], d[6:0] >= code_off_first};
    if (sc | sn) exp_hint = d[7];
    cmp_all();
    chk("core updates", 17'(sc), 17'(n_cu - cu));
    chk("nb updates", 17'(sn), 17'(n_nu - nu));
  endtask

  task automatic t_boot();
    logic [6:0] tab [4];
    tab = '{boot_code_00, boot_code_01, boot_code_10, boot_code_11};
    for (int k = 0; k < 4; k++) begin
      enable = 1'b0;
      i_svid_host.set_lines(k[1], k[0]);
      repeat (6) @(negedge clk);
      enable = 1'b1;
      repeat (8) @(negedge clk);
      {exp_core, exp_nb, exp_coff, exp_noff} = {tab[k], tab[k], 2'b00};
      cmp_all();
      chk("boot volt", 17'(11000 - 1000 * k), 17'(15500 - 125 * int'(core_code)));
      i_svid_host.set_lines(1'b1, 1'b1);
      repeat (4) @(negedge clk);
    end
    $display("test boot done");
  endtask

  task automatic t_cmds();
    logic [14:0] tab [11];
    tab = '{15'h6205, 15'h61fb, 15'h6310, 15'h637c, 15'h6120, 15'h64b0,
            15'h6a21, 15'h60b3, 15'h5244, 15'h6245, 15'h61ff};
    host_power_ok = 1'b1;
    repeat (5) @(negedge clk);
    for (int i = 0; i < 11; i++) cmd(tab[i][14:8], tab[i][7:0], i != 9);
    $display("test commands done");
  endtask

  task automatic t_pok();
    host_power_ok = 1'b0;
    repeat (8) @(negedge clk);
    {exp_core, exp_nb, exp_coff, exp_noff} = {boot_code_11, boot_code_11, 2'b00};
    cmp_all();
    cmd(7'h63, 8'h11, 1'b1);
    host_power_ok = 1'b1;
    repeat (5) @(negedge clk);
    cmd(7'h63, 8'h12, 1'b1);
    $display("test power ok done");
  endtask

  task automatic t_offs();
    for (int k = 0; k < 16; k++) begin
      core_offset_strap = 4'(k);
      nb_offset_strap = 4'(15 - k);
      repeat (8) @(negedge clk);
      chk("core offset", 17'(50000 - 6250 * k), core_uv);
      chk("nb offset", 17'(50000 - 6250 * (15 - k)), nb_uv);
    end
    $display("test offsets done");
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rstn, enable, host_power_ok, core_offset_strap, nb_offset_strap} = '0;
    {exp_hint, exp_coff, exp_noff} = 3'b100;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_boot();
    t_cmds();
    t_pok();
    t_offs();
    summarize();
  end

  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule

`default_nettype wire
